/* core/mcpt_pkg.sv */
// Shared constants and types for the multi-channel PWM and capture timer set
package mcpt_pkg;

  // Widths and channel counts
  localparam int MAIN_W = 16;
  localparam int T8_W   = 8;
  localparam int PRE_W  = 8;
  localparam int NCH    = 5;
  localparam int NT8    = 2;

  // Positions of the synchronised input pins inside the pin vector
  localparam int PIN_CAP0   = 0;
  localparam int PIN_MAINEV = 5;
  localparam int PIN_T8EV0  = 6;
  localparam int NPIN       = 8;

  // IR generation uses the first 8-bit timer as the envelope
  localparam int IR_T8 = 0;

  // Counting source of a timer
  typedef enum logic [1:0] {
    MCPT_MODE_STOP  = 2'b00,
    MCPT_MODE_FREE  = 2'b01,
    MCPT_MODE_EVENT = 2'b10
  } mcpt_mode_t;

  // Whole state of the timer set
  typedef struct packed {
    logic [NPIN-1:0]                pin_s1;
    logic [NPIN-1:0]                pin_s2;
    logic [NPIN-1:0]                pin_s3;
    logic [PRE_W-1:0]               main_pre;
    logic [MAIN_W-1:0]              main_cnt;
    logic [NCH-1:0][MAIN_W-1:0]     cap_val;
    logic [NCH-1:0]                 cap_evt;
    logic [NCH-1:0]                 ch_out;
    logic                           main_evt;
    logic [NT8-1:0][PRE_W-1:0]      t8_pre;
    logic [NT8-1:0][T8_W-1:0]       t8_cnt;
    logic [NT8-1:0]                 t8_out;
    logic [NT8-1:0]                 t8_evt;
  } mcpt_state_t;

  // Reset value of the state
  localparam mcpt_state_t STATE_RST = '0;

endpackage

/* core/mcpt_top.sv */
// Timer set: 16-bit five-channel timer and two 8-bit timers with PWM, capture and IR mode
`timescale 1ns/1ps
module mcpt_top
  import mcpt_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  mcpt_mode_t                        main_mode,
  input  wire logic [PRE_W-1:0]             main_div,
  input  wire logic [MAIN_W-1:0]            main_period,
  input  wire logic                         ir_en,
  input  wire logic [NCH-1:0]               ch_capture,
  input  wire logic [NCH-1:0][MAIN_W-1:0]   ch_cmp,
  input  mcpt_mode_t [NT8-1:0]              t8_mode,
  input  wire logic [NT8-1:0][PRE_W-1:0]    t8_div,
  input  wire logic [NT8-1:0][T8_W-1:0]     t8_period,
  input  wire logic [NT8-1:0][T8_W-1:0]     t8_cmp,
  input  wire logic [NCH-1:0]               ch_pin_in,
  input  wire logic                         main_evt_pin,
  input  wire logic [NT8-1:0]               t8_evt_pin,
  output logic [NCH-1:0]                    ch_pin_out,
  output logic [NCH-1:0]                    ch_pin_oe,
  output logic [NT8-1:0]                    t8_pin_out,
  output logic [MAIN_W-1:0]                 main_count,
  output logic [NCH-1:0][MAIN_W-1:0]        cap_value,
  output logic [NCH-1:0]                    cap_event,
  output logic                              main_period_evt,
  output logic [NT8-1:0]                    t8_period_evt
);

  mcpt_state_t          s_reg;
  mcpt_state_t          s_next;
  logic [NPIN-1:0]      edges;
  logic                 main_tick;
  logic                 main_wrap;
  logic [NT8-1:0]       t8_tick;
  logic [NT8-1:0]       t8_wrap;
  logic                 pwm_lvl;

  // Next-state logic for the whole timer set
  always_comb begin
    s_next    = s_reg;
    pwm_lvl   = 1'b0;
    main_tick = 1'b0;
    t8_tick   = '0;
    t8_wrap   = '0;
    // Pins pass three flops; edges are taken from the second and third
    s_next.pin_s1 = {t8_evt_pin, main_evt_pin, ch_pin_in};
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_s3 = s_reg.pin_s2;
    edges         = s_reg.pin_s2 & ~s_reg.pin_s3;

    for (int k = 0; k < NT8; k++) begin
      case (t8_mode[k])
        MCPT_MODE_FREE: begin
          if (s_reg.t8_pre[k] == t8_div[k]) begin
            t8_tick[k]       = 1'b1;
            s_next.t8_pre[k] = '0;
          end else begin
            s_next.t8_pre[k] = s_reg.t8_pre[k] + 8'h01;
          end
        end
        MCPT_MODE_EVENT: t8_tick[k] = edges[PIN_T8EV0 + k];
        default:         s_next.t8_pre[k] = '0;
      endcase
      t8_wrap[k] = t8_tick[k] && (s_reg.t8_cnt[k] == t8_period[k]);
      if (t8_wrap[k]) begin
        s_next.t8_cnt[k] = '0;
      end else if (t8_tick[k]) begin
        s_next.t8_cnt[k] = s_reg.t8_cnt[k] + 8'h01;
      end
      s_next.t8_evt[k] = t8_wrap[k];
      // compare output low from match until wrap
      s_next.t8_out[k] = s_next.t8_cnt[k] < t8_cmp[k];
    end

    case (main_mode)
      MCPT_MODE_FREE: begin
        if (ir_en) begin
          main_tick       = t8_wrap[IR_T8];
          s_next.main_pre = '0;
        end else if (s_reg.main_pre == main_div) begin
          main_tick       = 1'b1;
          s_next.main_pre = '0;
        end else begin
          s_next.main_pre = s_reg.main_pre + 8'h01;
        end
      end
      MCPT_MODE_EVENT: main_tick = edges[PIN_MAINEV];
      default:         s_next.main_pre = '0;
    endcase

    main_wrap = main_tick && (s_reg.main_cnt == main_period);
    if (main_wrap) begin
      s_next.main_cnt = '0;
    end else if (main_tick) begin
      s_next.main_cnt = s_reg.main_cnt + 16'h0001;
    end
    s_next.main_evt = main_wrap;

    for (int i = 0; i < NCH; i++) begin
      s_next.cap_evt[i] = ch_capture[i] && edges[PIN_CAP0 + i];
      if (s_next.cap_evt[i]) begin
        s_next.cap_val[i] = s_reg.main_cnt;
      end
      // level drops at match and returns at wrap
      pwm_lvl = s_next.main_cnt < ch_cmp[i];
      // gate carrier with the envelope in IR mode
      s_next.ch_out[i] = ir_en ? (pwm_lvl & s_next.t8_out[IR_T8]) : pwm_lvl;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs from the state register; pin drive enable is ch_capture inverted, not registered
  assign ch_pin_out      = s_reg.ch_out;
  assign ch_pin_oe       = ~ch_capture;
  assign t8_pin_out      = s_reg.t8_out;
  assign main_count      = s_reg.main_cnt;
  assign cap_value       = s_reg.cap_val;
  assign cap_event       = s_reg.cap_evt;
  assign main_period_evt = s_reg.main_evt;
  assign t8_period_evt   = s_reg.t8_evt;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_main_wrap_zero: assert property (main_wrap |=> main_count == 16'h0000 && main_period_evt)
    else $error("main counter did not wrap to zero with event");

  a_main_hold: assert property (!main_tick |=> $stable(main_count))
    else $error("main counter moved without a tick");

  a_main_step: assert property (main_tick && !main_wrap |=> main_count == $past(main_count) + 16'h0001)
    else $error("main counter did not step by one");

  // IR mode with free counting counts envelope periods only
  a_ir_count: assert property (ir_en && main_mode == MCPT_MODE_FREE && !t8_wrap[0] |=> $stable(main_count))
    else $error("main counter advanced without envelope period");

  a_ir_gate: assert property ($past(ir_en) && ch_pin_out[0] |-> t8_pin_out[0])
    else $error("IR output high while envelope low");

  // captured value is the count one cycle back
  a_cap_value: assert property (cap_event[1] |-> cap_value[1] == $past(main_count))
    else $error("capture did not hold the counter value");

  // main PWM level follows the compare
  a_pwm_level: assert property (!$past(ir_en) |-> ch_pin_out[1] == (main_count < $past(ch_cmp[1])))
    else $error("channel level does not match compare");

  a_t8_wrap_zero: assert property (t8_wrap[1] |=> t8_period_evt[1] && s_reg.t8_cnt[1] == 8'h00)
    else $error("8-bit timer period event missing");

  // 8-bit PWM level follows its compare
  a_t8_pwm: assert property (t8_pin_out[1] == (s_reg.t8_cnt[1] < $past(t8_cmp[1])))
    else $error("8-bit PWM level does not match compare");

  a_stop_hold: assert property (main_mode == MCPT_MODE_STOP |=> $stable(main_count))
    else $error("main counter moved in stop mode");

  // main period event only at zero
  a_main_evt_zero: assert property (main_period_evt |-> main_count == 16'h0000)
    else $error("main period event without zero count");

  // capture events only in capture mode
  a_cap_mode: assert property ((cap_event & ~$past(ch_capture)) == 5'h00)
    else $error("capture event on a compare channel");

  a_cap_hold: assert property (!cap_event[1] |-> $stable(cap_value[1]))
    else $error("captured value changed without an event");

  // 8-bit period event only at zero
  a_t8_evt_zero: assert property (t8_period_evt[0] |-> s_reg.t8_cnt[0] == 8'h00)
    else $error("8-bit period event without zero count");

  a_t8_step: assert property (t8_tick[0] && !t8_wrap[0] |=> s_reg.t8_cnt[0] == $past(s_reg.t8_cnt[0]) + 8'h01)
    else $error("8-bit counter did not step by one");

  // stopped 8-bit timer holds its count
  a_t8_stop: assert property (t8_mode[1] == MCPT_MODE_STOP |=> $stable(s_reg.t8_cnt[1]))
    else $error("8-bit counter moved in stop mode");

  // envelope PWM level follows its compare
  a_t8_pwm0: assert property (t8_pin_out[0] == (s_reg.t8_cnt[0] < $past(t8_cmp[0])))
    else $error("envelope PWM level does not match compare");

  // PWM of channel 2 gated by envelope
  a_ir_gate_pwm: assert property ($past(ir_en) |->
    ch_pin_out[2] == (main_count < $past(ch_cmp[2]) && t8_pin_out[0]))
    else $error("IR channel 2 level does not match gated compare");

endmodule

/* tb/mcpt_testbench.sv */
// Self-checking testbench for the timer set
`timescale 1ns/1ps
module testbench;
  import mcpt_pkg::*;
  logic                       clk_sys, rst, ir_en, main_evt_pin, main_period_evt;
  mcpt_mode_t                 main_mode;
  mcpt_mode_t [NT8-1:0]       t8_mode;
  logic [PRE_W-1:0]           main_div;
  logic [MAIN_W-1:0]          main_period, main_count;
  logic [NCH-1:0]             ch_capture, ch_pin_in, ch_pin_out, ch_pin_oe, cap_event;
  logic [NCH-1:0][MAIN_W-1:0] ch_cmp, cap_value;
  logic [NT8-1:0][PRE_W-1:0]  t8_div;
  logic [NT8-1:0][T8_W-1:0]   t8_period, t8_cmp;
  logic [NT8-1:0]             t8_evt_pin, t8_pin_out, t8_period_evt;
  int                         n_errors = 0;
  int                         checks = 0;

  mcpt_top u_dut (.clk_sys(clk_sys), .rst(rst), .main_mode(main_mode), .main_div(main_div),
    .main_period(main_period), .ir_en(ir_en), .ch_capture(ch_capture), .ch_cmp(ch_cmp),
    .t8_mode(t8_mode), .t8_div(t8_div), .t8_period(t8_period), .t8_cmp(t8_cmp),
    .ch_pin_in(ch_pin_in), .main_evt_pin(main_evt_pin), .t8_evt_pin(t8_evt_pin),
    .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe), .t8_pin_out(t8_pin_out),
    .main_count(main_count), .cap_value(cap_value), .cap_event(cap_event),
    .main_period_evt(main_period_evt), .t8_period_evt(t8_period_evt));

  // Value comparison, counted
  task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic timeout();
    n_errors++;
    $display("[ERR] %0t wait ran out", $time);
    print_verdict();
  endtask

  // Free count with prescaler, wrap pulse and PWM levels of all channels
  task automatic t_free(logic [7:0] div);
    logic [15:0] prev;
    int          k;
    main_period = 16'h0002;
    main_div = div;
    ch_cmp = {16'h0000, 16'h0005, 16'h0003, 16'h0002, 16'h0001};
    main_mode = MCPT_MODE_FREE;
    prev = main_count;
    for (k = 0; k < 10 && main_count === prev; k++) tick();
    if (k == 10) timeout();
    repeat (9) begin
      prev = main_count;
      tick(div + 1);
      chk(main_count, (prev == 16'h0002) ? 0 : prev + 1, "main count");
      chk(main_period_evt, main_count == 0, "main wrap pulse");
      for (int i = 0; i < NCH; i++) chk(ch_pin_out[i], main_count < ch_cmp[i], "pwm level");
    end
    main_mode = MCPT_MODE_STOP;
    tick();
  endtask

  // Capture on channel 1; channel 0 in compare mode ignores its pin
  task automatic t_capture();
    int          k;
    logic [15:0] held;
    main_div = 8'h00;
    main_mode = MCPT_MODE_FREE;
    ch_capture = 5'b00010;
    tick();
    chk(ch_pin_oe, 5'b11101, "pin drive enable");
    ch_pin_in = 5'b00011;
    held = main_count;
    for (k = 0; k < 8 && cap_event[1] !== 1'b1; k++) begin
      held = main_count;
      tick();
    end
    if (k == 8) timeout();
    chk(cap_value[1], held, "captured value");
    chk(cap_event[0], 0, "compare channel capture");
    tick();
    chk(cap_event, 0, "capture pulse length");
    ch_pin_in = 5'b00000;
    main_mode = MCPT_MODE_STOP;
  endtask

  // Event counting of pin rising edges on the main and first 8-bit timer
  task automatic t_event();
    logic [15:0] c0;
    int          n;
    main_period = 16'h00ff;
    main_mode = MCPT_MODE_EVENT;
    t8_mode[0] = MCPT_MODE_EVENT;
    tick(4);
    c0 = main_count;
    n = 0;
    for (int j = 0; j < 21; j++) begin
      main_evt_pin = (j % 6 < 3) && (j < 18);
      t8_evt_pin[0] = main_evt_pin;
      tick();
      n += t8_period_evt[0];
    end
    chk(main_count, c0 + 3, "event count");
    chk(n, 3, "8-bit event count");
    main_mode = MCPT_MODE_STOP;
    t8_mode[0] = MCPT_MODE_STOP;
  endtask

  // Second 8-bit timer: cycle length and PWM duty
  task automatic t_t8();
    int k;
    int hi;
    t8_div[1] = 8'h01;
    t8_period[1] = 8'h03;
    t8_cmp[1] = 8'h02;
    t8_mode[1] = MCPT_MODE_FREE;
    for (k = 0; k < 20 && t8_period_evt[1] !== 1'b1; k++) tick();
    if (k == 20) timeout();
    hi = 0;
    for (k = 1; k <= 20; k++) begin
      tick();
      hi += t8_pin_out[1];
      if (t8_period_evt[1] === 1'b1) break;
    end
    chk(k, 8, "t8 cycle length");
    chk(hi, 4, "t8 pwm high cycles");
    t8_mode[1] = MCPT_MODE_STOP;
  endtask

  // IR mode: main counts first 8-bit timer periods, output gated
  task automatic t_ir();
    int          n;
    logic [15:0] c0;
    c0 = main_count;
    n = 0;
    t8_period[0] = 8'h03;
    t8_cmp[0] = 8'h02;
    ch_cmp[0] = 16'hffff;
    main_period = 16'hffff;
    ir_en = 1'b1;
    main_mode = MCPT_MODE_FREE;
    t8_mode[0] = MCPT_MODE_FREE;
    repeat (30) begin
      tick();
      n += t8_period_evt[0];
      chk(ch_pin_out[0], t8_pin_out[0], "ir gated output");
      for (int i = 1; i < NCH; i++) chk(ch_pin_out[i], main_count < ch_cmp[i] && t8_pin_out[0], "ir gated pwm");
    end
    t8_mode[0] = MCPT_MODE_STOP;
    tick(4);
    chk(main_count, c0 + n, "ir period count");
  endtask

  // Clock, reset and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    rst = 1'b1;
    {ir_en, main_evt_pin, main_div, main_period, ch_capture, ch_pin_in} = '0;
    {ch_cmp, t8_div, t8_period, t8_cmp, t8_evt_pin} = '0;
    main_mode = MCPT_MODE_STOP;
    t8_mode[0] = MCPT_MODE_STOP;
    t8_mode[1] = MCPT_MODE_STOP;
    tick(12);
    rst = 1'b0;
    tick();
    chk(main_count, 0, "count after reset");
    t_free(8'h00);
    t_free(8'h02);
    t_capture();
    t_event();
    t_t8();
    t_ir();
    print_verdict();
  end
endmodule
